//--- pkg/pw_cfg.svh
// Constants of the program runaway watchdog: register map, fields, reset values and ratios.
//=====================================================================
`ifndef PW_CFG_SVH
`define PW_CFG_SVH

//=====================================================================
// Register byte offsets.
`define PW_ADR_CONTROL     8'h00
`define PW_ADR_RESTART     8'h04
`define PW_ADR_PROTECT     8'h08
`define PW_ADR_MODE_ONE    8'h0C
`define PW_ADR_MODE_TWO    8'h10
`define PW_ADR_CLOCK_ONE   8'h14
`define PW_ADR_COUNT       8'h18
`define PW_ADR_IRQ_STATUS  8'h1C
`define PW_ADR_IRQ_MASK    8'h20

//=====================================================================
// Field positions.
`define PW_BIT_RATIO_SEL   7
`define PW_BIT_UNLOCK      1
`define PW_BIT_ACTION      2
`define PW_BIT_PROTECT     2
`define PW_BIT_CLOCK_STOP  0
`define PW_BIT_RUNNING     15
`define PW_BIT_EV_UNDER    0

//=====================================================================
// Counter, ratios and fixed priority.
`define PW_CNT_W           15
`define PW_CNT_ALL_ONES    15'h7FFF
`define PW_FULL_COUNT      32768
`define PW_DIV_MAIN_LOW    8'h10
`define PW_DIV_MAIN_HIGH   8'h80
`define PW_DIV_SUB         8'h02
`define PW_IRQ_IPL         3'h7
`define PW_EV_W            1

`endif

//--- pkg/pw_pkg.sv
// Types shared by the program runaway watchdog modules.
package pw_pkg;

	// Which source advances the counter.
	typedef enum logic [1:0] {
		PW_SRC_MAIN = 2'b00,
		PW_SRC_SUB  = 2'b01,
		PW_SRC_RING = 2'b10
	} pw_src_e;

	typedef logic [14:0] pw_count_t;

endpackage

//--- pkg/pw_if.sv
// Interface joining the watchdog control logic with its prescaler and counter.
`timescale 1ns/10ps
interface pw_if;
	logic           pre_run;
	pw_pkg::pw_src_e src;
	logic           ratio_high;
	logic           pre_tick;
	logic           cnt_tick;
	logic           cnt_reload;
	pw_pkg::pw_count_t count;
	logic           underflow;

	modport ctrl (output pre_run, output src, output ratio_high, input pre_tick,
		output cnt_tick, output cnt_reload, input count, input underflow);
	modport pre (input pre_run, input src, input ratio_high, output pre_tick);
	modport cnt (input cnt_tick, input cnt_reload, output count, output underflow);
endinterface

//--- hdl/pw_prescaler.sv
// Prescaler dividing the CPU clock into counter ticks.
`timescale 1ns/10ps
`include "pw_cfg.svh"
module pw_prescaler (
	// Clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// Control side
	pw_if.pre         bus
);
	logic [7:0] div_reg;
	logic [7:0] ratio;

	always_comb begin
		unique case (bus.src)
			pw_pkg::PW_SRC_SUB:  ratio = `PW_DIV_SUB;
			default:             ratio = bus.ratio_high ? `PW_DIV_MAIN_HIGH : `PW_DIV_MAIN_LOW;
		endcase
	end

	// Only reset clears the divider; a restart leaves its phase alone.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			div_reg <= 8'h00;
		end else if (bus.pre_run) begin
			if (div_reg >= ratio - 8'h01) begin
				div_reg <= 8'h00;
			end else begin
				div_reg <= div_reg + 8'h01;
			end
		end
	end

	assign bus.pre_tick = bus.pre_run && (div_reg >= ratio - 8'h01);
endmodule

//--- hdl/pw_counter.sv
// Fifteen-bit watchdog down counter with reload and underflow pulse.
`timescale 1ns/10ps
`include "pw_cfg.svh"
module pw_counter (
	// Clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// Control side
	pw_if.cnt         bus
);
	pw_pkg::pw_count_t count_reg;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= `PW_CNT_ALL_ONES;
		end else if (bus.cnt_reload) begin
			count_reg <= `PW_CNT_ALL_ONES;
		end else if (bus.cnt_tick) begin
			count_reg <= count_reg - 15'h0001;
		end
	end

	assign bus.count     = count_reg;
	assign bus.underflow = bus.cnt_tick && !bus.cnt_reload && (count_reg == 15'h0000);
endmodule

//--- hdl/pw_top.sv
// Program runaway watchdog with Wishbone register access and interrupt logic.
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/10ps
`include "pw_cfg.svh"
module pw_top (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// CPU clock and power state
	input  wire logic        sub_clock_sel,
	input  wire logic        stop_mode,
	input  wire logic        wait_mode,
	input  wire logic        hold_state,
	// Ring oscillator
	input  wire logic        ring_osc_pin,
	output logic             ring_osc_en,
	// Watchdog results
	output logic             wdt_irq_req,
	output logic      [2:0]  wdt_irq_ipl,
	output logic             wdt_reset_req,
	output logic             stop_mode_req,
	output logic             irq
);

	//=====================================================================
	// Submodules.

	pw_if link ();

	pw_prescaler u_pre (
		.clock   (clock),
		.sys_rst (sys_rst),
		.bus     (link)
	);

	pw_counter u_cnt (
		.clock   (clock),
		.sys_rst (sys_rst),
		.bus     (link)
	);

	//=====================================================================
	// Bus decode.

	logic access;
	logic wr;
	logic wr_low;

	assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr     = access && wb_we_i;
	assign wr_low = wr && wb_sel_i[0];

	// Ack follows a request by one cycle, and a request still standing then is not taken twice.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= access;
		end
	end

	//=====================================================================
	// Control registers.

	logic ratio_high_reg;
	logic unlock_reg;
	logic action_reset_reg;
	logic protect_reg;
	logic clock_stop_reg;
	logic running_reg;

	// Register bits live in byte lane zero; the mode registers also need the unlock bit.
	logic wr_control;
	logic wr_protect;
	logic wr_mode_one;
	logic wr_mode_two;
	logic wr_clock_one;
	logic wr_irq_status;
	logic wr_irq_mask;

	assign wr_control    = wr_low && (wb_adr_i == `PW_ADR_CONTROL);
	assign wr_protect    = wr_low && (wb_adr_i == `PW_ADR_PROTECT);
	assign wr_mode_one   = wr_low && unlock_reg && (wb_adr_i == `PW_ADR_MODE_ONE);
	assign wr_mode_two   = wr_low && unlock_reg && (wb_adr_i == `PW_ADR_MODE_TWO);
	assign wr_clock_one  = wr_low && (wb_adr_i == `PW_ADR_CLOCK_ONE);
	assign wr_irq_status = wr_low && (wb_adr_i == `PW_ADR_IRQ_STATUS);
	assign wr_irq_mask   = wr_low && (wb_adr_i == `PW_ADR_IRQ_MASK);

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ratio_high_reg <= 1'b0;
		end else if (wr_control) begin
			ratio_high_reg <= wb_dat_i[`PW_BIT_RATIO_SEL];
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			unlock_reg <= 1'b0;
		end else if (wr_protect) begin
			unlock_reg <= wb_dat_i[`PW_BIT_UNLOCK];
		end
	end

	// The action bit only ever goes from interrupt to reset.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			action_reset_reg <= 1'b0;
		end else if (wr_mode_one) begin
			action_reset_reg <= action_reset_reg | wb_dat_i[`PW_BIT_ACTION];
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			protect_reg <= 1'b0;
		end else if (wr_mode_two) begin
			protect_reg <= wb_dat_i[`PW_BIT_PROTECT];
		end
	end

	// With the ring oscillator guarding the count, stopping all clocks is refused.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			clock_stop_reg <= 1'b0;
		end else if (protect_reg) begin
			clock_stop_reg <= 1'b0;
		end else if (wr_clock_one) begin
			clock_stop_reg <= wb_dat_i[`PW_BIT_CLOCK_STOP];
		end
	end

	//=====================================================================
	// Restart and run state.

	logic restart;

	assign restart = wr && wb_adr_i == `PW_ADR_RESTART;

	// Once started, only a system reset stops the count again.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			running_reg <= 1'b0;
		end else if (restart) begin
			running_reg <= 1'b1;
		end
	end

	//=====================================================================
	// Ring oscillator sampling.

	logic ring_s1_reg;
	logic ring_s2_reg;
	logic ring_s3_reg;
	logic ring_rise;

	// The first stage may go metastable, so only the second and third stages feed logic.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ring_s1_reg <= 1'b0;
			ring_s2_reg <= 1'b0;
			ring_s3_reg <= 1'b0;
		end else begin
			ring_s1_reg <= ring_osc_pin;
			ring_s2_reg <= ring_s1_reg;
			ring_s3_reg <= ring_s2_reg;
		end
	end

	assign ring_rise = ring_s2_reg && !ring_s3_reg;

	// The oscillator runs only while the protect bit asks for it.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ring_osc_en <= 1'b0;
		end else begin
			ring_osc_en <= protect_reg;
		end
	end

	//=====================================================================
	// Count source selection and freezing.

	logic freeze;
	pw_pkg::pw_src_e src;

	always_comb begin
		if (protect_reg) begin
			src = pw_pkg::PW_SRC_RING;
		end else if (sub_clock_sel) begin
			src = pw_pkg::PW_SRC_SUB;
		end else begin
			src = pw_pkg::PW_SRC_MAIN;
		end
	end

	// Wait mode does not freeze the ring-driven count.
	assign freeze = stop_mode || hold_state || (wait_mode && !protect_reg);

	assign link.src        = src;
	assign link.ratio_high = ratio_high_reg;
	assign link.pre_run    = running_reg && !freeze && !protect_reg;
	assign link.cnt_reload = restart;
	assign link.cnt_tick   = running_reg && !freeze &&
		(protect_reg ? ring_rise : link.pre_tick);

	//=====================================================================
	// Underflow action.

	// The reset pulse asks the system reset logic for a software-equivalent reset.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wdt_reset_req <= 1'b0;
		end else begin
			wdt_reset_req <= link.underflow && action_reset_reg;
		end
	end

	// The request is a pulse; the sticky status bit keeps the event for software.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wdt_irq_req <= 1'b0;
		end else begin
			wdt_irq_req <= link.underflow && !action_reset_reg;
		end
	end

	// A fixed top level places this request above every maskable source.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wdt_irq_ipl <= 3'h0;
		end else if (link.underflow && !action_reset_reg) begin
			wdt_irq_ipl <= `PW_IRQ_IPL;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			stop_mode_req <= 1'b0;
		end else begin
			stop_mode_req <= clock_stop_reg;
		end
	end

	//=====================================================================
	// Interrupt status and mask.

	logic [`PW_EV_W-1:0] status_reg;
	logic [`PW_EV_W-1:0] status_next;
	logic [`PW_EV_W-1:0] mask_reg;
	logic [`PW_EV_W-1:0] ev_set;
	logic [`PW_EV_W-1:0] ev_clr;

	assign ev_set = {link.underflow};
	assign ev_clr = wr_irq_status ?
		wb_dat_i[`PW_EV_W-1:0] : {`PW_EV_W{1'b0}};

	// A new event in the clearing cycle survives the clear.
	assign status_next = (status_reg & ~ev_clr) | ev_set;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			status_reg <= {`PW_EV_W{1'b0}};
		end else begin
			status_reg <= status_next;
		end
	end

	// A masked event still sets its status bit, so unmasking later raises irq at once.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mask_reg <= {`PW_EV_W{1'b0}};
		end else if (wr_irq_mask) begin
			mask_reg <= wb_dat_i[`PW_EV_W-1:0];
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_next & mask_reg);
		end
	end

	//=====================================================================
	// Read data.

	logic [31:0] rd_data;

	// Unmapped offsets and unused bits read as zero.
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (wb_adr_i)
			`PW_ADR_CONTROL: begin
				rd_data[`PW_BIT_RATIO_SEL] = ratio_high_reg;
			end
			`PW_ADR_PROTECT: begin
				rd_data[`PW_BIT_UNLOCK] = unlock_reg;
			end
			`PW_ADR_MODE_ONE: begin
				rd_data[`PW_BIT_ACTION] = action_reset_reg;
			end
			`PW_ADR_MODE_TWO: begin
				rd_data[`PW_BIT_PROTECT] = protect_reg;
			end
			`PW_ADR_CLOCK_ONE: begin
				rd_data[`PW_BIT_CLOCK_STOP] = clock_stop_reg;
			end
			`PW_ADR_COUNT: begin
				rd_data[`PW_CNT_W-1:0]    = link.count;
				rd_data[`PW_BIT_RUNNING] = running_reg;
			end
			`PW_ADR_IRQ_STATUS: begin
				rd_data[`PW_EV_W-1:0] = status_reg;
			end
			`PW_ADR_IRQ_MASK: begin
				rd_data[`PW_EV_W-1:0] = mask_reg;
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end

	// Read data is captured once, in the cycle that raises ack, and then stands.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (access && !wb_we_i) begin
			wb_dat_o <= rd_data;
		end
	end

endmodule

//--- bench/pw_top_props.sv
// Concurrent checks on the ports of the watchdog top module.
`timescale 1ns/10ps
module pw_top_props (
	// Clock and reset
	input wire logic       clock,
	input wire logic       sys_rst,
	// Bus
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic       wb_ack_o,
	// Power state
	input wire logic       stop_mode,
	input wire logic       wait_mode,
	input wire logic       hold_state,
	// Results
	input wire logic       ring_osc_en,
	input wire logic       wdt_irq_req,
	input wire logic [2:0] wdt_irq_ipl,
	input wire logic       wdt_reset_req,
	input wire logic       stop_mode_req,
	input wire logic       irq
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	logic started_reg;
	logic seen_rst_reg;
	//==========
	// Helpers.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			started_reg <= 1'b0;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h04) begin
			started_reg <= 1'b1;
		end
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			seen_rst_reg <= 1'b0;
		end else if (wdt_reset_req) begin
			seen_rst_reg <= 1'b1;
		end
	end
	//==========
	// Properties.
	sequence s_frozen;
		((stop_mode || hold_state || wait_mode) && !ring_osc_en)[*3];
	endsequence
	sequence s_bus_wr;
		wb_ack_o && wb_we_i;
	endsequence
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	property p_irq_pulse;
		wdt_irq_req |=> !wdt_irq_req;
	endproperty
	property p_rst_pulse;
		wdt_reset_req |=> !wdt_reset_req;
	endproperty
	property p_set_only;
		seen_rst_reg |-> !wdt_irq_req;
	endproperty
	property p_ipl;
		wdt_irq_req |-> ##[0:1] wdt_irq_ipl == 3'h7;
	endproperty
	property p_idle;
		!started_reg |-> !wdt_irq_req && !wdt_reset_req;
	endproperty
	property p_frozen;
		s_frozen |-> !wdt_irq_req && !wdt_reset_req;
	endproperty
	property p_stop_lock;
		$rose(stop_mode_req) |-> !$past(ring_osc_en);
	endproperty
	property p_irq_src;
		$rose(irq) |-> wdt_irq_req || wdt_reset_req || $past(wb_ack_o && wb_we_i);
	endproperty
	property p_ring;
		$rose(ring_osc_en) |-> s_bus_wr or $past(wb_ack_o && wb_we_i);
	endproperty
	a_ack: assert property (p_ack) else $error("ack not a one-cycle answer");
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq_req too long");
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset_req too long");
	a_set_only: assert property (p_set_only) else $error("interrupt after reset");
	a_ipl: assert property (p_ipl) else $error("ipl not 7");
	a_idle: assert property (p_idle) else $error("underflow before start");
	a_frozen: assert property (p_frozen) else $error("underflow while frozen");
	a_stop_lock: assert property (p_stop_lock) else $error("stop set in protect");
	a_irq_src: assert property (p_irq_src) else $error("irq without cause");
	a_ring: assert property (p_ring) else $error("ring enable without write");
endmodule
bind pw_top pw_top_props pw_top_props_inst (.clock(clock), .sys_rst(sys_rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_ack_o(wb_ack_o), .stop_mode(stop_mode), .wait_mode(wait_mode),
	.hold_state(hold_state), .ring_osc_en(ring_osc_en), .wdt_irq_req(wdt_irq_req),
	.wdt_irq_ipl(wdt_irq_ipl), .wdt_reset_req(wdt_reset_req),
	.stop_mode_req(stop_mode_req), .irq(irq));

//--- bench/testbench.sv
// Self-checking testbench of the program runaway watchdog.
`timescale 1ns/10ps
`include "pw_cfg.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
	logic        clock, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic        sub_clock_sel, stop_mode, wait_mode, hold_state, ring_osc_pin, ring_run;
	logic        ring_osc_en, wdt_irq_req, wdt_reset_req, stop_mode_req, irq;
	logic [2:0]  wdt_irq_ipl;
	int          failures, num_checks, n;

	pw_top pw_top_inst (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.sub_clock_sel(sub_clock_sel), .stop_mode(stop_mode), .wait_mode(wait_mode),
		.hold_state(hold_state), .ring_osc_pin(ring_osc_pin), .ring_osc_en(ring_osc_en),
		.wdt_irq_req(wdt_irq_req), .wdt_irq_ipl(wdt_irq_ipl), .wdt_reset_req(wdt_reset_req),
		.stop_mode_req(stop_mode_req), .irq(irq));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) if (ring_run) ring_osc_pin <= ~ring_osc_pin;

	//==========
	// Bus and helpers.
	task automatic stop_test;
		if (failures == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin @(posedge clock); t++; end while (wb_ack_o !== 1'b1 && t < 20);
		if (t >= 20) failures++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask
	// The prescaler keeps its phase across restarts, so allow one early tick.
	task automatic cntchk(input string nm, input int k);
		int dec;
		wb(1'b0, `PW_ADR_COUNT, 32'h0);
		dec = 32'h7FFF - int'(rd[14:0]);
		`CHK(nm, 1'b1, dec >= k - 1 && dec <= k + 2)
	endtask

	//==========
	// Scenarios.
	task automatic t_idle;
		`CHK("ipl", 3'h0, wdt_irq_ipl)
		rdchk("count", `PW_ADR_COUNT, 32'h7FFF);
		cyc(100);
		rdchk("count idle", `PW_ADR_COUNT, 32'h7FFF);
		rdchk("unmapped", 8'hFC, 32'h0);
		wb_sel_i <= 4'hE;
		wb(1'b1, `PW_ADR_CONTROL, 32'h80);
		wb_sel_i <= 4'hF;
		rdchk("lane gate", `PW_ADR_CONTROL, 32'h0);
	endtask
	task automatic t_rates;
		wb(1'b1, `PW_ADR_RESTART, 32'h5A);
		cyc(800);
		cntchk("div16", 50);
		wb(1'b1, `PW_ADR_CONTROL, 32'h80);
		wb(1'b1, `PW_ADR_RESTART, 32'h0);
		cyc(1280);
		cntchk("div128", 10);
		sub_clock_sel <= 1'b1;
		wb(1'b1, `PW_ADR_RESTART, 32'h0);
		cyc(200);
		cntchk("div2", 101);
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, `PW_ADR_RESTART, 32'h0);
			{stop_mode, wait_mode, hold_state} <= 3'h1 << i;
			cyc(100);
			{stop_mode, wait_mode, hold_state} <= 3'h0;
			cntchk("frozen", 1);
		end
	endtask
	task automatic t_irq;
		wb(1'b1, `PW_ADR_IRQ_MASK, 32'h1);
		wb(1'b1, `PW_ADR_RESTART, 32'h0);
		n = 0;
		do begin @(posedge clock); n++; end while (wdt_irq_req !== 1'b1 && n < 70000);
		`CHK("period", 1'b1, n >= 65530 && n <= 65542)
		@(posedge clock);
		`CHK("reset_req", 1'b0, wdt_reset_req)
		`CHK("irq", 1'b1, irq)
		`CHK("ipl", 3'h7, wdt_irq_ipl)
		rdchk("status", `PW_ADR_IRQ_STATUS, 32'h1);
		wb(1'b1, `PW_ADR_IRQ_MASK, 32'h0);
		`CHK("masked", 1'b0, irq)
		wb(1'b1, `PW_ADR_IRQ_MASK, 32'h1);
		`CHK("unmasked", 1'b1, irq)
		wb(1'b1, `PW_ADR_IRQ_STATUS, 32'h1);
		`CHK("cleared", 1'b0, irq)
		wb(1'b1, `PW_ADR_RESTART, 32'h0);
	endtask
	task automatic t_protect;
		wb(1'b1, `PW_ADR_MODE_ONE, 32'h4);
		rdchk("locked", `PW_ADR_MODE_ONE, 32'h0);
		wb(1'b1, `PW_ADR_CLOCK_ONE, 32'h1);
		`CHK("stop", 1'b1, stop_mode_req)
		wb(1'b1, `PW_ADR_CLOCK_ONE, 32'h0);
		wb(1'b1, `PW_ADR_PROTECT, 32'h2);
		wb(1'b1, `PW_ADR_MODE_ONE, 32'h4);
		wb(1'b1, `PW_ADR_MODE_ONE, 32'h0);
		rdchk("set only", `PW_ADR_MODE_ONE, 32'h4);
		wb(1'b1, `PW_ADR_MODE_TWO, 32'h4);
		wb(1'b1, `PW_ADR_PROTECT, 32'h0);
		`CHK("ring en", 1'b1, ring_osc_en)
		wb(1'b1, `PW_ADR_CLOCK_ONE, 32'h1);
		`CHK("stop lock", 1'b0, stop_mode_req)
		ring_run <= 1'b1;
		wb(1'b1, `PW_ADR_RESTART, 32'h0);
		wait_mode <= 1'b1;
		cyc(200);
		cntchk("wait runs", 100);
		wait_mode <= 1'b0;
	endtask

	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hF;
		{sub_clock_sel, stop_mode, wait_mode, hold_state, ring_osc_pin, ring_run} = '0;
		failures = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		cyc(12);
		sys_rst <= 1'b0;
		cyc(1);
		t_idle();
		t_rates();
		t_irq();
		sys_rst <= 1'b1;
		cyc(2);
		sys_rst <= 1'b0;
		sub_clock_sel <= 1'b0;
		cyc(1);
		t_protect();
		stop_test();
	end
	// The run needs about seventy thousand cycles; this bound leaves ample margin.
	initial begin
		#900000;
		failures++;
		stop_test();
	end
endmodule
